// ### pke_host_pkg.sv
// Shared constants and types for the public key accelerator host port
package pke_host_pkg;

    // ------------------------------------------------------------------
    // Window map
    // ------------------------------------------------------------------
    localparam int          ADDR_W        = 13;           // Byte address into the window
    localparam logic [12:0] WINDOW_BYTES  = 13'h1C00;     // 7 KB window
    localparam logic [12:0] RAM_A_BASE    = 13'h0400;     // First operand RAM
    localparam logic [12:0] RAM_B_BASE    = 13'h1000;     // Second operand RAM
    localparam int          WORD_W        = 32;           // Datapath and access width
    localparam int          RAM_DEPTH     = 512;          // Words per operand RAM
    localparam int          RAM_AW        = 9;            // Word address width of a RAM
    localparam logic [12:0] RAM_BYTES     = 13'h0800;     // Byte span of one RAM
    localparam logic [3:0]  NUM_SLOTS     = 4'hA;         // Host operand slots 0..9

    // ------------------------------------------------------------------
    // Slot spacing in words for each base width layout
    // ------------------------------------------------------------------
    localparam logic [1:0]  WSEL_256      = 2'h0;
    localparam logic [1:0]  WSEL_512      = 2'h1;
    localparam logic [1:0]  WSEL_1024     = 2'h2;
    localparam logic [8:0]  STRIDE_256    = 9'h009;       // 0x24 bytes
    localparam logic [8:0]  STRIDE_512    = 9'h011;       // 0x44 bytes
    localparam logic [8:0]  STRIDE_1024   = 9'h021;       // 0x84 bytes

    // ------------------------------------------------------------------
    // Program memory
    // ------------------------------------------------------------------
    localparam int          PROG_BYTES    = 2048;         // Microcode store size
    localparam int          PROG_DEPTH    = PROG_BYTES / 4;
    localparam int          PC_W          = 9;

    // Microcode operations
    typedef enum logic [3:0] {
        OP_END = 4'h0,
        OP_ADD = 4'h1,
        OP_SUB = 4'h2,
        OP_MOV = 4'h3
    } op_t;

    // Microcode instruction layout
    typedef struct packed {
        op_t        op;        // Operation
        logic       dst_b;     // Destination RAM: 1 second, 0 first
        logic [6:0] rsv0;
        logic [3:0] dst;       // Destination slot
        logic [3:0] rsv1;
        logic [3:0] sa;        // Source slot in first RAM
        logic [3:0] rsv2;
        logic [3:0] sb;        // Source slot in second RAM
    } instr_t;

    // Host access request and answer
    typedef struct packed {
        logic              wr;     // Write strobe, one cycle
        logic              rd;     // Read strobe, one cycle
        logic [ADDR_W-1:0] addr;   // Byte address, word aligned
        logic [WORD_W-1:0] wdata;  // Write word
    } host_req_t;

    typedef struct packed {
        logic              valid;  // Read answer pulse
        logic [WORD_W-1:0] data;   // Read word
    } host_rsp_t;

    // Engine status seen by the host
    typedef struct packed {
        logic          busy;       // Computation running
        logic          done;       // Target operation finished
        logic          stopped;    // Last run was aborted
        logic [PC_W-1:0] pc;       // Current microcode address
    } pke_status_t;

endpackage

// ### pke_host_port.sv
// Public key accelerator: host window, operand RAMs and microcode engine
// Functional notes
// R1: Everything host visible sits in 7 KB window
// R2: Least significant word at lowest address
// R3: Datapath takes 32-bit words only
// R4: Host zero-pads unused top word bits
// R5: Idle until start, then run configured operation
// R6: Status reports running state during computation
// R7: Host may abort computation via stop
// R8: Operand RAMs stay host readable while running
// R9: Completion seen by status flag and interrupt
// R10: Operand accesses are aligned whole words
// R11: First RAM at 0x400, second at 0x1000
// R12: Ten slots, spacing set by width layout
// R13: Supports 192 and 256 bit precisions
// R14: Microcode from internal 2 KB program memory
// R15: Program memory, execution unit, ALU, two RAMs
// R16: Internal RAM part hidden from host
// R17: Start launches next cycle with current config
// R18: Stop halts engine on next cycle
// R19: Interrupt gated by enable; status unaffected
// R20: Active word count sets operand width
`timescale 1ns/1ps
`default_nettype none

module pke_host_port
    import pke_host_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    nrst,
    input  wire pke_host_pkg::host_req_t host_req,
    output var  pke_host_pkg::host_rsp_t host_rsp,
    input  wire logic                    start_cmd,
    input  wire logic                    stop_cmd,
    input  wire logic                    interrupt_gate_bit,
    input  wire logic [1:0]              base_width_select,
    input  wire logic [7:0]              active_word_count,
    output var  pke_host_pkg::pke_status_t status,
    output logic                         irq
);
    import pke_host_pkg::*;

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------

    // Slot spacing in words for a layout
    function automatic logic [8:0] slot_stride(input logic [1:0] wsel);
        case (wsel)
            WSEL_512:  slot_stride = STRIDE_512;
            WSEL_1024: slot_stride = STRIDE_1024;
            default:   slot_stride = STRIDE_256;
        endcase
    endfunction

    // Word address of a slot start
    function automatic logic [RAM_AW-1:0] slot_base(input logic [3:0] slot,
                                                   input logic [1:0] wsel);
        logic [12:0] prod;
        prod = 13'(slot) * 13'(slot_stride(wsel));
        slot_base = prod[RAM_AW-1:0];
    endfunction

    // Microcode store, unused locations end the program
    function automatic instr_t prog_word(input logic [PC_W-1:0] addr);
        logic [31:0] w;
        case (addr)
            9'h000:  w = 32'h1002_0000;  // First RAM slot 2 = A0 + B0
            9'h001:  w = 32'h2802_0000;  // Second RAM slot 2 = A0 - B0
            9'h002:  w = 32'h3803_0201;  // Second RAM slot 3 = A2
            default: w = 32'h0000_0000;
        endcase
        prog_word = instr_t'(w);
    endfunction

    // ------------------------------------------------------------------
    // Host address decode
    // ------------------------------------------------------------------
    logic [8:0]        host_stride;   // Spacing under the layout taken at start
    logic [12:0]       a_off;         // Byte offset into first RAM
    logic [12:0]       b_off;         // Byte offset into second RAM
    logic              in_a;          // Visible first RAM word
    logic              in_b;          // Visible second RAM word
    logic [RAM_AW-1:0] host_word;     // Word index in the selected RAM
    logic [12:0]       vis_words;     // Host visible words per RAM
    logic [1:0]        cfg_wsel;      // Layout taken at start
    logic [1:0]        next_cfg_wsel; // Layout for the next cycle

    always_comb begin
        host_stride = slot_stride(cfg_wsel);
        vis_words   = 13'(NUM_SLOTS) * 13'(host_stride);
        a_off       = host_req.addr - RAM_A_BASE;
        b_off       = host_req.addr - RAM_B_BASE;
        // Misaligned or outside the window: no RAM is touched
        in_a = (host_req.addr[1:0] == 2'h0) && (host_req.addr < WINDOW_BYTES)   // R1 R10
            && (host_req.addr >= RAM_A_BASE) && (a_off < RAM_BYTES)             // R11
            && ({2'h0, a_off[12:2]} < vis_words);                               // R12 R16
        in_b = (host_req.addr[1:0] == 2'h0) && (host_req.addr < WINDOW_BYTES)
            && (host_req.addr >= RAM_B_BASE) && (b_off < RAM_BYTES)             // R11
            && ({2'h0, b_off[12:2]} < vis_words);                               // R12 R16
        host_word = in_b ? b_off[10:2] : a_off[10:2];
    end

    // ------------------------------------------------------------------
    // Engine control state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {S_IDLE, S_FETCH, S_READ, S_EXEC} eng_state_t;

    eng_state_t      state,     next_state;      // Sequencer state
    logic [PC_W-1:0] pc,        next_pc;         // Microcode address
    instr_t          ir,        next_ir;         // Current instruction
    logic [7:0]      widx,      next_widx;       // Word within operand
    logic            carry,     next_carry;      // ALU carry between words
    logic [7:0]      cfg_words, next_cfg_words;  // Word count taken at start
    logic            done,      next_done;       // Completion flag
    logic            stopped,   next_stopped;    // Abort flag
    logic            irq_q,     next_irq;        // Gated interrupt
    logic            busy_q,    next_busy;       // Running flag

    // Engine RAM port signals
    logic [WORD_W-1:0] eng_a_q;     // First RAM read word
    logic [WORD_W-1:0] eng_b_q;     // Second RAM read word
    logic [RAM_AW-1:0] eng_ra;      // First RAM read address
    logic [RAM_AW-1:0] eng_rb;      // Second RAM read address
    logic [RAM_AW-1:0] eng_wa;      // Write address
    logic              eng_we_a;    // Write first RAM
    logic              eng_we_b;    // Write second RAM
    logic [WORD_W:0]   alu_sum;     // 32-bit ALU result with carry
    logic [WORD_W-1:0] alu_b;       // Second ALU operand

    // Engine addresses and 32-bit arithmetic unit
    always_comb begin
        eng_ra   = slot_base(ir.sa, cfg_wsel) + RAM_AW'(widx);    // R2
        eng_rb   = slot_base(ir.sb, cfg_wsel) + RAM_AW'(widx);    // R2
        eng_wa   = slot_base(ir.dst, cfg_wsel) + RAM_AW'(widx);   // R2
        alu_b    = (ir.op == OP_SUB) ? ~eng_b_q : eng_b_q;
        alu_sum  = {1'b0, eng_a_q} + {1'b0, alu_b} + {32'h0, carry}; // R3 R15
        if (ir.op == OP_MOV) begin
            alu_sum = {1'b0, eng_a_q};
        end
        eng_we_a = (state == S_EXEC) && !ir.dst_b;
        eng_we_b = (state == S_EXEC) && ir.dst_b;
    end

    // Sequencer next values
    always_comb begin
        next_state     = state;
        next_pc        = pc;
        next_ir        = ir;
        next_widx      = widx;
        next_carry     = carry;
        next_cfg_wsel  = cfg_wsel;
        next_cfg_words = cfg_words;
        next_done      = done;
        next_stopped   = stopped;
        case (state)
            S_IDLE: begin
                // Waits for start; configuration sampled in the start cycle
                if (start_cmd) begin                                  // R5 R17
                    next_state     = S_FETCH;
                    next_pc        = '0;
                    next_cfg_wsel  = base_width_select;               // R17
                    next_cfg_words = active_word_count;               // R13 R20
                    next_done      = 1'b0;
                    next_stopped   = 1'b0;
                end
            end
            S_FETCH: begin
                // Load instruction from program memory
                next_ir    = prog_word(pc);                           // R14
                next_widx  = '0;
                next_carry = (next_ir.op == OP_SUB);
                if (next_ir.op == OP_END || cfg_words == 8'h00) begin
                    next_state = S_IDLE;
                    next_done  = 1'b1;                                // R9
                end else begin
                    next_state = S_READ;
                end
            end
            S_READ: begin
                // RAM read addresses issued this cycle
                next_state = S_EXEC;
            end
            S_EXEC: begin
                // Word result written, carry rippled to the next word
                next_carry = alu_sum[WORD_W];
                if (widx + 8'h01 >= cfg_words) begin                  // R20
                    next_state = S_FETCH;
                    next_pc    = pc + 9'h001;
                end else begin
                    next_widx  = widx + 8'h01;                        // R2
                    next_state = S_READ;
                end
            end
            default: next_state = S_IDLE;
        endcase
        // Abort wins over any step in progress
        if (stop_cmd && state != S_IDLE) begin                        // R7 R18
            next_state   = S_IDLE;
            next_stopped = 1'b1;
            // An aborted run never reports completion
            next_done    = 1'b0;
        end
        next_busy = (next_state != S_IDLE);                           // R6
        next_irq  = next_done && interrupt_gate_bit;                  // R19
    end

    // Sequencer registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state     <= S_IDLE;
            pc        <= '0;
            ir        <= '0;
            widx      <= '0;
            carry     <= 1'b0;
            cfg_wsel  <= WSEL_256;
            cfg_words <= '0;
            done      <= 1'b0;
            stopped   <= 1'b0;
            irq_q     <= 1'b0;
            busy_q    <= 1'b0;
        end else begin
            state     <= next_state;
            pc        <= next_pc;
            ir        <= next_ir;
            widx      <= next_widx;
            carry     <= next_carry;
            cfg_wsel  <= next_cfg_wsel;
            cfg_words <= next_cfg_words;
            done      <= next_done;
            stopped   <= next_stopped;
            irq_q     <= next_irq;
            busy_q    <= next_busy;
        end
    end

    // ------------------------------------------------------------------
    // Operand RAMs
    // ------------------------------------------------------------------
    logic [WORD_W-1:0] ram_a [RAM_DEPTH];   // First operand RAM
    logic [WORD_W-1:0] ram_b [RAM_DEPTH];   // Second operand RAM
    logic              host_we_a;           // Host write to first RAM
    logic              host_we_b;           // Host write to second RAM

    // Host writes only while idle so operands stay stable
    always_comb begin
        host_we_a = host_req.wr && in_a && !busy_q;   // R10
        host_we_b = host_req.wr && in_b && !busy_q;   // R10
    end

    // Array ports: engine and host, upper part only engine reachable
    always_ff @(posedge clk_sys) begin
        if (host_we_a) begin
            ram_a[host_word] <= host_req.wdata;
        end
        if (host_we_b) begin
            ram_b[host_word] <= host_req.wdata;
        end
        if (eng_we_a) begin
            ram_a[eng_wa] <= alu_sum[WORD_W-1:0];   // R15 R16
        end
        if (eng_we_b) begin
            ram_b[eng_wa] <= alu_sum[WORD_W-1:0];   // R15 R16
        end
        eng_a_q <= ram_a[eng_ra];
        eng_b_q <= ram_b[eng_rb];
    end

    // ------------------------------------------------------------------
    // Host read answer
    // ------------------------------------------------------------------

    // Reads served at any time, running or not; unmapped reads give zero
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            host_rsp <= '0;
        end else begin
            host_rsp.valid <= host_req.rd;
            if (host_req.rd && in_a) begin
                host_rsp.data <= ram_a[host_word];    // R8
            end else if (host_req.rd && in_b) begin
                host_rsp.data <= ram_b[host_word];    // R8
            end else if (host_req.rd) begin
                host_rsp.data <= '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------------
    always_comb begin
        status.busy    = busy_q;    // R6
        status.done    = done;      // R9 R19
        status.stopped = stopped;
        status.pc      = pc;
        irq            = irq_q;     // R9 R19
    end

endmodule // pke_host_port

`default_nettype wire

// ### pke_host_port_monitor.sv
// Concurrent checks on the ports of the public key accelerator host port
`timescale 1ns/1ps
`default_nettype none

module pke_host_port_monitor
    import pke_host_pkg::*;
(
    input wire logic                      clk_sys,
    input wire logic                      nrst,
    input wire pke_host_pkg::host_req_t   host_req,
    input wire pke_host_pkg::host_rsp_t   host_rsp,
    input wire logic                      start_cmd,
    input wire logic                      stop_cmd,
    input wire logic                      interrupt_gate_bit,
    input wire logic [1:0]                base_width_select,
    input wire logic [7:0]                active_word_count,
    input wire pke_host_pkg::pke_status_t status,
    input wire logic                      irq
);
    // ------------------------------------------------------------------
    // One clock domain, reset disables every check
    // ------------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    chk_read_answer: assert property (host_req.rd |=> host_rsp.valid)
        else $error("read strobe got no answer");
    chk_valid_cause: assert property (host_rsp.valid |-> $past(host_req.rd))
        else $error("read answer without a read");
    chk_unmapped_zero: assert property (
        (host_req.rd && (host_req.addr >= 13'h1C00 || host_req.addr[1:0] != 2'h0))
        |=> host_rsp.data == 32'h0000_0000) else $error("unmapped read not zero");
    chk_start_launch: assert property (
        (start_cmd && !status.busy && active_word_count != 8'h00)
        |=> (status.busy && !status.done && !status.stopped)) else $error("start not taken");
    chk_stop_halt: assert property ((stop_cmd && status.busy)
        |=> (!status.busy && status.stopped && !status.done)) else $error("stop not taken");
    chk_idle_hold: assert property ((!status.busy && !start_cmd)
        |=> (!status.busy && $stable({status.done, status.stopped})))
        else $error("idle engine changed state");
    chk_busy_done_excl: assert property (status.busy |-> !status.done)
        else $error("busy and done together");
    chk_irq_gate: assert property (irq == (status.done && $past(interrupt_gate_bit)))
        else $error("interrupt not equal to gated done");
    chk_run_bound: assert property (
        (start_cmd && !status.busy && active_word_count <= 8'h10)
        |-> ##[1:120] !status.busy) else $error("short run did not finish");
endmodule // pke_host_port_monitor

bind pke_host_port pke_host_port_monitor pke_host_port_monitor_i (
    .clk_sys            (clk_sys),
    .nrst               (nrst),
    .host_req           (host_req),
    .host_rsp           (host_rsp),
    .start_cmd          (start_cmd),
    .stop_cmd           (stop_cmd),
    .interrupt_gate_bit (interrupt_gate_bit),
    .base_width_select  (base_width_select),
    .active_word_count  (active_word_count),
    .status             (status),
    .irq                (irq)
);

`default_nettype wire

// ### pke_host_model.sv
// Behavioural host core that issues single word accesses to the window
`timescale 1ns/1ps
`default_nettype none

module pke_host_model
    import pke_host_pkg::*;
(
    input  wire logic                    clk_sys,
    output var  pke_host_pkg::host_req_t host_req,
    input  wire pke_host_pkg::host_rsp_t host_rsp
);
    // Bus starts quiet
    initial host_req = '0;

    // One word write; operands go in whole, zero-padded words, low word first
    task automatic write_word(input logic [12:0] addr, input logic [31:0] data);
        @(posedge clk_sys);
        host_req <= '{1'b1, 1'b0, addr, data};
        @(posedge clk_sys);
        // Released bus shows the inverse so stale values never look valid
        host_req <= '{1'b0, 1'b0, ~addr, ~data};
    endtask

    // One word read; answer taken one edge after the strobe
    task automatic read_word(input logic [12:0] addr, output logic [32:0] got);
        @(posedge clk_sys);
        host_req <= '{1'b0, 1'b1, addr, ~host_req.wdata};
        @(posedge clk_sys);
        host_req <= '{1'b0, 1'b0, ~addr, host_req.wdata};
        #1;
        got = {host_rsp.valid, host_rsp.data};
    endtask
endmodule // pke_host_model

`default_nettype wire

// ### testbench.sv
// Self-checking testbench for the public key accelerator host port
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import pke_host_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [12:0] addr;   // Window address
        logic [31:0] wdata;  // Word written
        logic [31:0] exp;    // Word expected back
    } row_t;
    logic        clk_sys;             // System clock
    logic        nrst;                // Active low reset
    host_req_t   host_req;            // Request from host model
    host_rsp_t   host_rsp;            // Read answer
    logic        start_cmd;           // Start pulse
    logic        stop_cmd;            // Stop pulse
    logic        interrupt_gate_bit;  // Interrupt enable
    logic [1:0]  base_width_select;   // Layout select
    logic [7:0]  active_word_count;   // Words per operand
    pke_status_t status;              // Engine status
    logic        irq;                 // Interrupt line
    int          errors;              // Mismatch count
    int          total_checks;        // Comparison count
    logic [32:0] got;                 // Valid and data from a read
    // Ordinary accesses in the reset (256) layout
    row_t rows [8] = '{'{13'h0400, 32'hAAAA5555, 32'hAAAA5555},
        '{13'h0564, 32'h12345678, 32'h12345678}, '{13'h0568, 32'h0F0F0F0F, 32'h0},
        '{13'h1000, 32'hC3C3C3C3, 32'hC3C3C3C3}, '{13'h1168, 32'h5A5A5A5A, 32'h0},
        '{13'h0402, 32'h11111111, 32'h0}, '{13'h1C00, 32'h22222222, 32'h0},
        '{13'h0C00, 32'h33333333, 32'h0}};
    // Operand loads (0..4) and results after a two word run (5..12)
    logic [44:0] ops [13] = '{{13'h0400, 32'hFFFFFFFF}, {13'h0404, 32'h00000001},
        {13'h1000, 32'h00000001}, {13'h1004, 32'h00000002}, {13'h0450, 32'h00000099},
        {13'h0448, 32'h00000000}, {13'h044C, 32'h00000004}, {13'h1048, 32'hFFFFFFFE},
        {13'h104C, 32'hFFFFFFFF}, {13'h106C, 32'h00000000}, {13'h1070, 32'h00000004},
        {13'h0450, 32'h00000099}, {13'h0400, 32'hFFFFFFFF}};
    logic [12:0] slot1 [4] = '{13'h0424, 13'h0444, 13'h0484, 13'h0424};
    logic [12:0] inner [4] = '{13'h0568, 13'h06A8, 13'h0928, 13'h0568};

    // ------------------------------------------------------------------
    // Clock, design and host model
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    pke_host_port pke_host_port_i (.clk_sys(clk_sys), .nrst(nrst), .host_req(host_req),
        .host_rsp(host_rsp), .start_cmd(start_cmd), .stop_cmd(stop_cmd),
        .interrupt_gate_bit(interrupt_gate_bit), .base_width_select(base_width_select),
        .active_word_count(active_word_count), .status(status), .irq(irq));
    pke_host_model pke_host_model_i (.clk_sys(clk_sys), .host_req(host_req),
        .host_rsp(host_rsp));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    // Compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    // Pulse start or stop for one edge, then look just after the launch edge
    task automatic cmd(input logic go, input logic halt);
        @(posedge clk_sys);
        start_cmd <= go;
        stop_cmd  <= halt;
        @(posedge clk_sys);
        start_cmd <= 1'b0;
        stop_cmd  <= 1'b0;
        #1;
    endtask
    // Bounded wait for the engine to go idle
    task automatic wait_idle;
        int n;
        n = 0;
        while (status.busy !== 1'b0 && n < 300) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check("idle wait", 32'(n < 300), 32'h1);
    endtask
    // Read a word and compare data and answer
    task automatic rd_chk(input logic [12:0] a, input logic [31:0] exp);
        pke_host_model_i.read_word(a, got);
        check("read valid", 32'(got[32]), 32'h1);
        check("read data", got[31:0], exp);
    endtask
    // Verdict, reached once
    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog far beyond the expected run of about 160 cycles
    initial begin
        #20000;
        errors++;
        final_report();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        errors = 0;
        total_checks = 0;
        nrst = 1'b0;
        start_cmd = 1'b0;
        stop_cmd = 1'b0;
        interrupt_gate_bit = 1'b0;
        base_width_select = 2'h0;
        active_word_count = 8'h00;
        repeat (3) @(posedge clk_sys);
        check("reset status", 32'(status), 32'h0);
        check("reset irq", 32'(irq), 32'h0);
        nrst <= 1'b1;
        // Table of plain accesses
        foreach (rows[i]) begin
            pke_host_model_i.write_word(rows[i].addr, rows[i].wdata);
            rd_chk(rows[i].addr, rows[i].exp);
        end
        // Two word add, subtract and move with carry and borrow
        for (int i = 0; i < 5; i++) pke_host_model_i.write_word(ops[i][44:32], ops[i][31:0]);
        @(posedge clk_sys);
        interrupt_gate_bit <= 1'b1;
        active_word_count  <= 8'h02;
        cmd(1'b1, 1'b0);
        check("busy at start", 32'(status.busy), 32'h1);
        pke_host_model_i.write_word(13'h0400, 32'h0);
        rd_chk(13'h0404, 32'h00000001);
        wait_idle();
        check("done flag", 32'(status.done), 32'h1);
        check("end address", 32'(status.pc), 32'h3);
        check("irq on done", 32'(irq), 32'h1);
        for (int i = 5; i < 13; i++) rd_chk(ops[i][44:32], ops[i][31:0]);
        // Gate off drops the line but not the flag
        @(posedge clk_sys);
        interrupt_gate_bit <= 1'b0;
        @(posedge clk_sys);
        #1;
        check("irq gated", 32'(irq), 32'h0);
        check("done kept", 32'(status.done), 32'h1);
        cmd(1'b0, 1'b1);
        check("stop idle", 32'(status.stopped), 32'h0);
        // 192-bit run aborted mid-way, extra start ignored
        @(posedge clk_sys);
        base_width_select <= 2'h1;
        active_word_count <= 8'h06;
        cmd(1'b1, 1'b0);
        cmd(1'b1, 1'b0);
        check("busy kept", 32'(status.busy), 32'h1);
        cmd(1'b0, 1'b1);
        check("status after stop", 32'({status.busy, status.done, status.stopped}),
            32'h1);
        // Every layout code, decoded after an empty run
        for (int w = 0; w < 4; w++) begin
            @(posedge clk_sys);
            base_width_select <= 2'(w);
            active_word_count <= 8'h00;
            cmd(1'b1, 1'b0);
            wait_idle();
            check("empty run done", 32'(status.done), 32'h1);
            pke_host_model_i.write_word(slot1[w], 32'h0000_0100 + 32'(w));
            rd_chk(slot1[w], 32'h0000_0100 + 32'(w));
            pke_host_model_i.write_word(inner[w] - 13'h4, 32'h0000_0200 + 32'(w));
            rd_chk(inner[w] - 13'h4, 32'h0000_0200 + 32'(w));
            pke_host_model_i.write_word(inner[w], 32'hDEAD_0000);
            rd_chk(inner[w], 32'h0);
        end
        // Reset in mid-run clears the whole status at once
        @(posedge clk_sys);
        active_word_count <= 8'h08;
        cmd(1'b1, 1'b0);
        nrst <= 1'b0;
        #1;
        check("reset mid-run", 32'(status), 32'h0);
        @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        final_report();
    end
endmodule // testbench

`default_nettype wire
